// file: core/bsdac_defs.svh
// Register map, field positions and timing counts of the bitstream converter
`ifndef BSDAC_DEFS_SVH
`define BSDAC_DEFS_SVH

`define BSDAC_OFS_SAMPLE  8'h00
`define BSDAC_OFS_CONTROL 8'h08
`define BSDAC_OFS_MASK    8'h0C
`define BSDAC_OFS_IEN     8'h10
`define BSDAC_OFS_IDIS    8'h14
`define BSDAC_OFS_ICLR    8'h18
`define BSDAC_OFS_STATUS  8'h1C

`define BSDAC_BIT_EN   31
`define BSDAC_BIT_SWAP 30
`define BSDAC_BIT_RDY  29
`define BSDAC_BIT_UND  28

`define BSDAC_RST_WORD 32'h0000_0000
`define BSDAC_RESP_OKAY   2'h0
`define BSDAC_RESP_SLVERR 2'h2

// Conversion clock edges per sample, and oversampling ratio
`define BSDAC_TICKS_PER_SAMPLE 256
`define BSDAC_TICK_W 8
`define BSDAC_OSR 128

// FIR gain of 8 and CIC gain of 2**21 are removed together
`define BSDAC_OUT_SHIFT 24
// Modulator input scaling 13/8 and feedback level
`define BSDAC_SDM_SHIFT 3
`define BSDAC_SDM_FB 131072

`endif

// file: core/bsdac_pkg.sv
// Shared types of the bitstream converter
package bsdac_pkg;
  typedef enum logic [0:0] {
    BSDAC_WR_COLLECT,
    BSDAC_WR_RESP
  } bsdac_wr_state_type;
  typedef logic signed [15:0] bsdac_sample_type;
endpackage

// file: core/bsdac_interp.sv
// Equalizing FIR and fourth-order CIC interpolator for one channel
`timescale 1ns/10ps
`default_nettype none
`include "bsdac_defs.svh"
module bsdac_interp #(
  parameter int CW = 44
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        clr,
  input  wire logic                        load,
  input  wire logic                        step,
  input  wire bsdac_pkg::bsdac_sample_type sample,
  output logic signed [17:0]               y
);
  typedef struct packed {
    logic [15:0]        x1;
    logic [15:0]        x2;
    logic [3:0][CW-1:0] cd;
    logic [CW-1:0]      co;
    logic               inj;
    logic [3:0][CW-1:0] ig;
    logic [17:0]        y;
  } bsdac_interp_st_type;
  bsdac_interp_st_type s;
  bsdac_interp_st_type n;

  function automatic logic [CW-1:0] sx(input logic [15:0] v);
    return {{(CW-16){v[15]}}, v};
  endfunction

  always_comb begin
    logic [CW-1:0] c;
    c = '0;
    n = s;
    // Zero-stuffed integrators at 128 times the sample rate
    if (step) begin
      n.ig[0] = s.ig[0] + (s.inj ? s.co : '0);
      for (int k = 1; k < 4; k++) begin
        n.ig[k] = s.ig[k] + s.ig[k-1];
      end
      n.inj = 1'b0;
      n.y = s.ig[3][`BSDAC_OUT_SHIFT +: 18];
    end
    if (load) begin
      // Taps -1, 10, -1 lift the passband that the sinc droops
      c = (sx(s.x1) <<< 3) + (sx(s.x1) <<< 1) - sx(sample) - sx(s.x2);
      for (int k = 0; k < 4; k++) begin
        n.cd[k] = c;
        c = c - s.cd[k];
      end
      n.co = c;
      n.inj = 1'b1;
      n.x2 = s.x1;
      n.x1 = sample;
    end
    if (clr) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign y = s.y;
endmodule
`default_nettype wire

// file: core/bsdac_sdm.sv
// Third-order one-bit sigma-delta modulator for one channel
`timescale 1ns/10ps
`default_nettype none
`include "bsdac_defs.svh"
module bsdac_sdm #(
  parameter int MW = 26
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clr,
  input  wire logic               step,
  input  wire logic signed [17:0] v,
  output logic                    bit_o,
  output logic                    bit_inv
);
  typedef struct packed {
    logic [MW-1:0] i1;
    logic [MW-1:0] i2;
    logic [MW-1:0] i3;
    logic          bit_o;
    logic          bit_inv;
  } bsdac_sdm_st_type;
  localparam bsdac_sdm_st_type SDM_RST = '{default: '0, bit_inv: 1'b1};
  localparam logic [MW-1:0] FB = MW'(`BSDAC_SDM_FB);
  bsdac_sdm_st_type s;
  bsdac_sdm_st_type n;

  function automatic logic [MW-1:0] asr(input logic [MW-1:0] a,
                                        input int k);
    return $unsigned($signed(a) >>> k);
  endfunction

  always_comb begin
    logic [MW-1:0] e;
    logic [MW-1:0] x;
    logic [MW-1:0] fb;
    e = {{(MW-18){v[17]}}, v};
    x = asr((e <<< 3) + (e <<< 2) + e, `BSDAC_SDM_SHIFT);
    // A true bit of one stands for a negative level: inverted polarity
    fb = s.bit_o ? (~FB + 1'b1) : FB;
    n = s;
    if (step) begin
      n.i1 = s.i1 + asr(x - fb, 2);
      n.i2 = s.i2 + asr(s.i1 - fb, 1);
      n.i3 = s.i3 + (s.i2 - fb);
      n.bit_o = n.i3[MW-1];
      n.bit_inv = ~n.i3[MW-1];
    end
    if (clr) begin
      n = SDM_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= SDM_RST;
    end else begin
      s <= n;
    end
  end

  assign bit_o = s.bit_o;
  assign bit_inv = s.bit_inv;
endmodule
`default_nettype wire

// file: core/bsdac_top.sv
// Stereo bitstream converter: AXI4-Lite registers, sample handoff, channels
// Functional notes
// - Each channel drives a bitstream and its complement.
// - Control bit 31 enables the block; resets to zero.
// - Ready status flag rises when a new sample word can be taken.
// - Sample must arrive within 256 conversion clocks, else underrun flagged.
// - Status read clears flags; clear register clears bits written one.
// - Channel samples are signed two's complement 16-bit values.
// - Channel 0 from bits 15..0, channel 1 from bits 31..16.
// - Control bit 30 swaps the halfwords of each sample write.
// - DMA is requested whenever ready; enable alone suffices.
// - Two third-order modulators, oversampling ratio 128.
// - Three-tap FIR equalizer before the interpolator.
// - Fourth-order CIC interpolator raises the rate by 128.
// - Modulator: three integrators, each with feedback, one-bit quantizer.
// - Full positive gives density near 38/128, negative near 90/128.
// - Mask set via enable, cleared via disable register; bits 29, 28.
// - Underrun flag stays set until reset or cleared.
// - Ready status reads zero while a word cannot be taken.
`timescale 1ns/10ps
`default_nettype none
`include "bsdac_defs.svh"
module bsdac_top #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          conversion_clock,
  output logic               dma_req,
  output logic               irq,
  output logic               bitstream_out_a,
  output logic               bitstream_out_a_inv,
  output logic               bitstream_out_b,
  output logic               bitstream_out_b_inv
);
  typedef struct packed {
    bsdac_pkg::bsdac_wr_state_type wst;
    logic                          aw_have;
    logic [AW-1:0]                 aw_addr;
    logic                          w_have;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic                          en;
    logic                          swap;
    logic [1:0]                    mask;
    logic                          st_ready;
    logic                          st_underrun;
    logic                          ready;
    logic                          irq;
    logic [31:0]                   sample_word;
    logic                          buf_full;
    logic [31:0]                   chan_word;
    logic                          cs1;
    logic                          cs2;
    logic                          cs3;
    logic [`BSDAC_TICK_W-1:0]      tick_cnt;
    logic                          load;
    logic                          step;
  } bsdac_top_st_type;

  localparam logic [`BSDAC_TICK_W-1:0] TICK_LAST =
    `BSDAC_TICK_W'(`BSDAC_TICKS_PER_SAMPLE - 1);

  bsdac_top_st_type s;
  bsdac_top_st_type n;

  logic          aw_hs;
  logic          w_hs;
  logic          ar_hs;
  logic          wr_go;
  logic [AW-1:0] wa;
  logic [31:0]   wd;
  logic [31:0]   bmask;
  logic [31:0]   wr_data;
  logic [31:0]   wr_bm;
  logic [1:0]    fbits;
  logic          wr_sdr;
  logic          wr_ctrl;
  logic          wr_ien;
  logic          wr_idis;
  logic          wr_iclr;
  logic          rd_clr;
  logic          und_set;
  logic [1:0]    clr_bits;
  logic          ready_nxt;
  logic          conv_edge;
  logic [1:0]    bits_true;
  logic [1:0]    bits_inv;

  function automatic logic at(input logic [AW-1:0] a, input logic [7:0] o);
    return a == AW'(o);
  endfunction

  function automatic logic [31:0] halfswap(input logic [31:0] v);
    return {v[15:0], v[31:16]};
  endfunction

  function automatic logic [31:0] bytemask(input logic [3:0] st);
    return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    if (at(a, `BSDAC_OFS_SAMPLE) || at(a, `BSDAC_OFS_CONTROL)) begin
      return 1'b1;
    end else if (at(a, `BSDAC_OFS_MASK) || at(a, `BSDAC_OFS_IEN)) begin
      return 1'b1;
    end else if (at(a, `BSDAC_OFS_IDIS) || at(a, `BSDAC_OFS_ICLR)) begin
      return 1'b1;
    end else if (at(a, `BSDAC_OFS_STATUS)) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  always_comb begin
    n = s;
    aw_hs = s_axi_awvalid & s_axi_awready;
    w_hs = s_axi_wvalid & s_axi_wready;
    ar_hs = s_axi_arvalid & s_axi_arready;
    // Conversion clock is a pin: two flops, then edge detect on the second
    n.cs1 = conversion_clock;
    n.cs2 = s.cs1;
    n.cs3 = s.cs2;
    conv_edge = s.cs2 & ~s.cs3;
    n.load = 1'b0;
    n.step = 1'b0;
    und_set = 1'b0;
    rd_clr = 1'b0;

    // Write channel: address and data may arrive in either order
    wr_go = 1'b0;
    wa = s.aw_have ? s.aw_addr : s_axi_awaddr;
    wd = s.w_have ? s.w_data : s_axi_wdata;
    bmask = bytemask(s.w_have ? s.w_strb : s_axi_wstrb);
    case (s.wst)
      bsdac_pkg::BSDAC_WR_COLLECT: begin
        if (aw_hs) begin
          n.aw_have = 1'b1;
          n.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
          n.w_have = 1'b1;
          n.w_data = s_axi_wdata;
          n.w_strb = s_axi_wstrb;
        end
        if ((s.aw_have | aw_hs) && (s.w_have | w_hs)) begin
          wr_go = 1'b1;
          n.aw_have = 1'b0;
          n.w_have = 1'b0;
          n.wst = bsdac_pkg::BSDAC_WR_RESP;
          n.bresp = mapped(wa) ? `BSDAC_RESP_OKAY : `BSDAC_RESP_SLVERR;
        end
      end
      default: begin
        if (s_axi_bready) begin
          n.wst = bsdac_pkg::BSDAC_WR_COLLECT;
        end
      end
    endcase
    wr_sdr = wr_go && at(wa, `BSDAC_OFS_SAMPLE);
    wr_ctrl = wr_go && at(wa, `BSDAC_OFS_CONTROL);
    wr_ien = wr_go && at(wa, `BSDAC_OFS_IEN);
    wr_idis = wr_go && at(wa, `BSDAC_OFS_IDIS);
    wr_iclr = wr_go && at(wa, `BSDAC_OFS_ICLR);
    // Swap happens on the way in, so a read shows the stored order
    wr_data = s.swap ? halfswap(wd) : wd;
    wr_bm = s.swap ? halfswap(bmask) : bmask;
    fbits = {wd[`BSDAC_BIT_RDY] & bmask[`BSDAC_BIT_RDY],
             wd[`BSDAC_BIT_UND] & bmask[`BSDAC_BIT_UND]};
    if (wr_ctrl && bmask[`BSDAC_BIT_EN]) begin
      n.en = wd[`BSDAC_BIT_EN];
      n.swap = wd[`BSDAC_BIT_SWAP];
    end
    if (wr_ien) begin
      n.mask = s.mask | fbits;
    end
    if (wr_idis) begin
      n.mask = s.mask & ~fbits;
    end

    // Sample period: 256 conversion edges, modulator step every second
    if (!s.en) begin
      n.tick_cnt = '0;
      n.buf_full = 1'b0;
    end else if (conv_edge) begin
      n.tick_cnt = s.tick_cnt + 1'b1;
      n.step = s.tick_cnt[0];
      if (s.tick_cnt == TICK_LAST) begin
        n.load = 1'b1;
        if (s.buf_full) begin
          n.chan_word = s.sample_word;
          n.buf_full = 1'b0;
        end else begin
          // Late writer: the last sample is replayed
          und_set = 1'b1;
        end
      end
    end
    if (wr_sdr) begin
      n.sample_word = (s.sample_word & ~wr_bm) | (wr_data & wr_bm);
      n.buf_full = s.en;
    end

    // Read channel, one outstanding read
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rresp = `BSDAC_RESP_OKAY;
      n.rdata = `BSDAC_RST_WORD;
      if (at(s_axi_araddr, `BSDAC_OFS_SAMPLE)) begin
        n.rdata = s.sample_word;
      end else if (at(s_axi_araddr, `BSDAC_OFS_CONTROL)) begin
        n.rdata[`BSDAC_BIT_EN] = s.en;
        n.rdata[`BSDAC_BIT_SWAP] = s.swap;
      end else if (at(s_axi_araddr, `BSDAC_OFS_MASK)) begin
        n.rdata[`BSDAC_BIT_RDY] = s.mask[1];
        n.rdata[`BSDAC_BIT_UND] = s.mask[0];
      end else if (at(s_axi_araddr, `BSDAC_OFS_STATUS)) begin
        n.rdata[`BSDAC_BIT_RDY] = s.st_ready;
        n.rdata[`BSDAC_BIT_UND] = s.st_underrun;
        rd_clr = 1'b1;
      end else if (!mapped(s_axi_araddr)) begin
        n.rresp = `BSDAC_RESP_SLVERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // Status flags: a set in the same cycle beats any clear
    clr_bits = (wr_iclr ? fbits : 2'b00) | {rd_clr, rd_clr};
    ready_nxt = n.en & ~n.buf_full;
    n.ready = ready_nxt;
    n.st_ready = (s.st_ready & ~clr_bits[1]) | (ready_nxt & ~s.ready);
    if (!ready_nxt) begin
      n.st_ready = 1'b0;
    end
    n.st_underrun = (s.st_underrun & ~clr_bits[0]) | und_set;
    n.irq = |({n.st_ready, n.st_underrun} & n.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = (s.wst == bsdac_pkg::BSDAC_WR_COLLECT) & ~s.aw_have;
  assign s_axi_wready = (s.wst == bsdac_pkg::BSDAC_WR_COLLECT) & ~s.w_have;
  assign s_axi_bvalid = (s.wst == bsdac_pkg::BSDAC_WR_RESP);
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign dma_req = s.ready;
  assign irq = s.irq;

  // Channel g takes halfword g of the loaded word
  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic signed [17:0] level;
    bsdac_interp u_interp (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clr     (~s.en),
      .load    (s.load),
      .step    (s.step),
      .sample  (s.chan_word[16*g +: 16]),
      .y       (level)
    );
    bsdac_sdm u_sdm (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clr     (~s.en),
      .step    (s.step),
      .v       (level),
      .bit_o   (bits_true[g]),
      .bit_inv (bits_inv[g])
    );
  end

  assign bitstream_out_a = bits_true[0];
  assign bitstream_out_a_inv = bits_inv[0];
  assign bitstream_out_b = bits_true[1];
  assign bitstream_out_b_inv = bits_inv[1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_OUT_COMPL: assert property (
    bitstream_out_a != bitstream_out_a_inv &&
    bitstream_out_b != bitstream_out_b_inv)
    else $error("bitstream and complement disagree");
  AST_EN_BIT: assert property (
    wr_ctrl && bmask[`BSDAC_BIT_EN] |=> s.en == $past(wd[`BSDAC_BIT_EN]))
    else $error("enable bit not taken from control write");
  AST_RDY_SET: assert property ($rose(dma_req) |-> s.st_ready)
    else $error("ready status not raised with ready");
  AST_UNDERRUN: assert property (
    s.load && !$past(s.buf_full) |-> s.st_underrun)
    else $error("missed sample not flagged as underrun");
  AST_READ_CLR: assert property (
    rd_clr && !und_set && !(ready_nxt && !s.ready) |=>
    !s.st_underrun && !s.st_ready)
    else $error("status read did not clear flags");
  AST_SWAP: assert property (
    wr_sdr && s.swap && bmask == 32'hFFFF_FFFF |=>
    s.sample_word[15:0] == $past(wd[31:16]) &&
    s.sample_word[31:16] == $past(wd[15:0]))
    else $error("swapped write stored in wrong order");
  AST_DMA_DROP: assert property (dma_req && wr_sdr |=> !dma_req)
    else $error("DMA request held after sample write");
  AST_MASK_SET: assert property (wr_ien && fbits[1] |=> s.mask[1])
    else $error("mask bit not set by enable write");
  AST_STICKY: assert property (
    $past(s.st_underrun) && !$past(clr_bits[0]) |-> s.st_underrun)
    else $error("underrun flag dropped without clear");
  AST_RDY_ZERO: assert property (s.buf_full || !s.en |-> !s.st_ready)
    else $error("ready status set while word cannot be taken");
  AST_IRQ: assert property (
    (s.st_underrun && s.mask[0]) || (s.st_ready && s.mask[1]) |-> irq)
    else $error("interrupt low with masked-in status");
  AST_QUIET: assert property (
    !s.en [*2] |-> !bitstream_out_a && !bitstream_out_b && !dma_req)
    else $error("activity while disabled");

  COV_UNDERRUN: cover property ($rose(s.st_underrun));
  COV_SWAP_WR: cover property (wr_sdr && s.swap);
  COV_LOAD_FULL: cover property (s.load ##1 dma_req);
  COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: testbench/bsdac_dma_model.sv
// Bus master model: DMA channel and processor on the register bus
`timescale 1ns/10ps
`default_nettype none
module bsdac_dma_model (
  input  wire logic        aclk,
  input  wire logic        dma_req,
  input  wire logic        auto_en,
  input  wire logic [31:0] auto_word,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic [1:0] r;
  bit         ok;
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] rs, output bit k);
    bit ad;
    bit dd;
    ad = 1'b0;
    dd = 1'b0;
    k = 1'b0;
    rs = 2'h3;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (bvalid && ad && dd) begin
        rs = bresp;
        k = 1'b1;
        bready <= 1'b0;
        break;
      end
      // Released lines show the inverse so stale values never pass
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs, output bit k);
    bit ad;
    ad = 1'b0;
    k = 1'b0;
    rs = 2'h3;
    d = 32'h0000_0000;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (rvalid && ad) begin
        d = rdata;
        rs = rresp;
        k = 1'b1;
        rready <= 1'b0;
        break;
      end
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    @(posedge aclk);
  endtask
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    forever begin
      @(posedge aclk);
      if (auto_en && dma_req) begin
        wr(8'h00, auto_word, r, ok);
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_stereo_sigma_delta_bitstream_dac.sv
// Self-checking bench of the stereo bitstream converter
`timescale 1ns/10ps
`default_nettype none
`include "bsdac_defs.svh"
module tb_stereo_sigma_delta_bitstream_dac;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, auto_word, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, cdiv;
  logic        aclk, aresetn, conversion_clock, auto_en, dma_req, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        out_a, out_a_inv, out_b, out_b_inv;
  int          failures;
  int          checks;
  logic [7:0]  regs [7] = '{`BSDAC_OFS_SAMPLE, `BSDAC_OFS_CONTROL,
    `BSDAC_OFS_MASK, `BSDAC_OFS_IEN, `BSDAC_OFS_IDIS, `BSDAC_OFS_ICLR,
    `BSDAC_OFS_STATUS};
  bsdac_top #(.AW(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conversion_clock(conversion_clock), .dma_req(dma_req), .irq(irq),
    .bitstream_out_a(out_a), .bitstream_out_a_inv(out_a_inv),
    .bitstream_out_b(out_b), .bitstream_out_b_inv(out_b_inv));
  bsdac_dma_model dma_u (.aclk(aclk), .dma_req(dma_req), .auto_en(auto_en),
    .auto_word(auto_word), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Conversion clock at a quarter of the bus clock, edges tied to it
  always @(posedge aclk) begin
    if (!aresetn) begin
      cdiv <= 2'h0;
      conversion_clock <= 1'b0;
    end else begin
      cdiv <= cdiv + 2'h1;
      conversion_clock <= cdiv[1];
    end
  end
  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Densities are statistical, so a band of 12/128 is allowed
  task automatic chk_rng(input int got, input int exp, input string what);
    checks++;
    if (got < exp - 12 || got > exp + 12) begin
      failures++;
      $display("wrong value at %0t: %s got %0d want %0d", $time, what, got,
               exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    dma_u.wr(a, w, r, ok);
    if (!ok) begin
      failures++;
      results();
    end
    chk({30'h0, r}, {30'h0, er}, "bresp");
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    dma_u.rd(a, d, r, ok);
    if (!ok) begin
      failures++;
      results();
    end
    chk({30'h0, r}, {30'h0, er}, "rresp");
    chk(d & m, e, "rdata");
  endtask
  task automatic dens(input logic [31:0] w, input int ea, input int eb);
    int na;
    int nb;
    na = 0;
    nb = 0;
    auto_word <= w;
    auto_en <= 1'b1;
    repeat (8192) @(posedge aclk);
    repeat (8192) begin
      @(posedge aclk);
      na += out_a;
      nb += out_b;
      chk({30'h0, out_a_inv, out_b_inv}, {30'h0, ~out_a, ~out_b}, "inv");
    end
    auto_en <= 1'b0;
    repeat (16) @(posedge aclk);
    chk_rng(na / 64, ea, "density a");
    chk_rng(nb / 64, eb, "density b");
  endtask
  initial begin
    failures = 0;
    checks = 0;
    aresetn = 1'b0;
    auto_en = 1'b0;
    auto_word = 32'h0000_0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({26'h0, dma_req, irq, out_a, out_a_inv, out_b, out_b_inv},
        32'h0000_0005, "idle pins");
    for (int i = 0; i < 7; i++) begin
      rc(regs[i], 32'hffff_ffff, 32'h0000_0000, `BSDAC_RESP_OKAY);
    end
    rc(8'h04, 32'hffff_ffff, 32'h0000_0000, `BSDAC_RESP_SLVERR);
    wr(8'h20, 32'hffff_ffff, `BSDAC_RESP_SLVERR);
    wr(8'h09, 32'hffff_ffff, `BSDAC_RESP_SLVERR);
    rc(`BSDAC_OFS_CONTROL, 32'hffff_ffff, 32'h0000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_IEN, 32'h3000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_IEN, 32'h0000_0000, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_MASK, 32'hffff_ffff, 32'h3000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_IDIS, 32'h2000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_IDIS, 32'h0000_0000, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_MASK, 32'hffff_ffff, 32'h1000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_SAMPLE, 32'h1234_abcd, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_SAMPLE, 32'hffff_ffff, 32'h1234_abcd, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_CONTROL, 32'h4000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_SAMPLE, 32'h1234_abcd, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_SAMPLE, 32'hffff_ffff, 32'habcd_1234, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_CONTROL, 32'h8000_0000, `BSDAC_RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk({31'h0, dma_req}, 32'h0000_0001, "dma_req");
    rc(`BSDAC_OFS_STATUS, 32'h2000_0000, 32'h2000_0000, `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_STATUS, 32'h3000_0000, 32'h0000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_SAMPLE, 32'h0000_0000, `BSDAC_RESP_OKAY);
    chk({31'h0, dma_req}, 32'h0000_0000, "dma_req");
    rc(`BSDAC_OFS_STATUS, 32'h2000_0000, 32'h0000_0000, `BSDAC_RESP_OKAY);
    // No further word: the second load after this must underrun
    repeat (2200) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001, "irq");
    rc(`BSDAC_OFS_STATUS, 32'h1000_0000, 32'h1000_0000, `BSDAC_RESP_OKAY);
    repeat (1100) @(posedge aclk);
    wr(`BSDAC_OFS_ICLR, 32'h1000_0000, `BSDAC_RESP_OKAY);
    chk({31'h0, irq}, 32'h0000_0000, "irq");
    rc(`BSDAC_OFS_STATUS, 32'h1000_0000, 32'h0000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_CONTROL, 32'h0000_0000, `BSDAC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    repeat (64) begin
      @(posedge aclk);
      chk({26'h0, dma_req, irq, out_a, out_a_inv, out_b, out_b_inv},
          32'h0000_0005, "disabled pins");
    end
    rc(`BSDAC_OFS_STATUS, 32'hffff_ffff, 32'h0000_0000,
       `BSDAC_RESP_OKAY);
    rc(`BSDAC_OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, `BSDAC_RESP_OKAY);
    wr(`BSDAC_OFS_CONTROL, 32'h8000_0000, `BSDAC_RESP_OKAY);
    dens(32'h8000_7fff, 38, 90);
    wr(`BSDAC_OFS_CONTROL, 32'hc000_0000, `BSDAC_RESP_OKAY);
    dens(32'h8000_7fff, 90, 38);
    rc(`BSDAC_OFS_STATUS, 32'h1000_0000, 32'h0000_0000, `BSDAC_RESP_OKAY);
    results();
  end
  initial begin
    #900000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
